// ---- dmbi_consts.svh ----
`ifndef DMBI_CONSTS_SVH
`define DMBI_CONSTS_SVH
`define DMBI_ADDR_W 32
`define DMBI_DATA_W 40
`define DMBI_WORD_LSB 8
`define DMBI_WORD_MSB 39
`define DMBI_BANKS 4
`define DMBI_PAGE_SHIFT_RST 5'h08
`define DMBI_BANK_SHIFT_RST 5'h1e
`define DMBI_MIN_ACK_CYCLES 1
`endif

// ---- dmbi_pkg.sv ----
package dmbi_pkg;
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [39:0] wdata;
  } dmbi_req_type;
  typedef struct packed {
    logic [4:0] page_shift;
    logic [4:0] bank_shift;
  } dmbi_cfg_type;
  typedef enum logic [1:0] {
    DMBI_IDLE, DMBI_ACCESS, DMBI_FLOAT, DMBI_GRANT
  } dmbi_state_type;
endpackage

// ---- dmbi_core.sv ----
`include "dmbi_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module dmbi_core #(
  parameter int ADDR_W = `DMBI_ADDR_W,
  parameter int DATA_W = `DMBI_DATA_W,
  parameter int BANKS = `DMBI_BANKS
) (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic CLK_EN,
  input wire dmbi_pkg::dmbi_req_type CORE_REQ,
  input wire dmbi_pkg::dmbi_cfg_type MEM_CFG,
  output logic CORE_READY,
  output logic CORE_HALT,
  output logic [DATA_W-1:0] CORE_RDATA,
  output logic CORE_RVALID,
  output logic [ADDR_W-1:0] DATA_MEM_ADDR_O,
  output logic DATA_MEM_ADDR_OE,
  input wire logic [DATA_W-1:0] DATA_MEM_DATA_I,
  output logic [DATA_W-1:0] DATA_MEM_DATA_O,
  output logic DATA_MEM_DATA_OE,
  output logic [BANKS-1:0] DATA_MEM_BANK_SELECT_N_O,
  output logic DATA_MEM_READ_STROBE_N_O,
  output logic DATA_MEM_WRITE_STROBE_N_O,
  output logic DATA_MEM_CTRL_OE,
  output logic DATA_MEM_PAGE_CROSS,
  input wire logic DATA_MEM_ACKNOWLEDGE,
  input wire logic DATA_MEM_FLOAT_CONTROL_N,
  input wire logic BUS_REQUEST_N,
  output logic BUS_GRANT_N
);
  import dmbi_pkg::*;

  function automatic logic [ADDR_W-1:0] page_of(
    input logic [ADDR_W-1:0] a, input logic [4:0] sh);
    page_of = a >> sh;
  endfunction

  dmbi_state_type state_q;
  dmbi_state_type state_d;
  logic breq_meta_q;
  logic breq_meta_d;
  logic breq_sync_q;
  logic breq_sync_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] wdata_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic write_q;
  logic write_d;
  logic [BANKS-1:0] bank_q;
  logic [BANKS-1:0] bank_d;
  logic rd_n_q;
  logic rd_n_d;
  logic wr_n_q;
  logic wr_n_d;
  logic addr_oe_q;
  logic addr_oe_d;
  logic data_oe_q;
  logic data_oe_d;
  logic ctrl_oe_q;
  logic ctrl_oe_d;
  logic page_q;
  logic page_d;
  logic rvalid_q;
  logic rvalid_d;
  logic ready_q;
  logic ready_d;
  logic halt_q;
  logic halt_d;
  logic grant_n_q;
  logic grant_n_d;
  logic [ADDR_W-1:0] last_page_q;
  logic [ADDR_W-1:0] last_page_d;
  logic floated;
  logic take;
  logic done;
  logic [ADDR_W-1:0] bank_word;
  logic [BANKS-1:0] bank_sel_n;

  assign bank_word = CORE_REQ.addr >> MEM_CFG.bank_shift;

  // one comparator per select, low on a match
  for (genvar g = 0; g < BANKS; g++) begin : g_bank
    assign bank_sel_n[g] = bank_word[1:0] != 2'(g);
  end

  always_comb begin
    breq_meta_d = ~BUS_REQUEST_N;
    breq_sync_d = breq_meta_q;
  end

  // second stage only, first stage feeds nothing else
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      breq_meta_q <= 1'b0;
      breq_sync_q <= 1'b0;
    end else if (CLK_EN) begin
      breq_meta_q <= breq_meta_d;
      breq_sync_q <= breq_sync_d;
    end
  end

  assign floated = ~DATA_MEM_FLOAT_CONTROL_N;
  assign take = state_q == DMBI_IDLE && !breq_sync_q && CORE_REQ.valid;
  assign done = state_q == DMBI_ACCESS && !floated && DATA_MEM_ACKNOWLEDGE;

  // page memory survives grants; first access compares with page 0
  always_comb begin
    last_page_d = last_page_q;
    page_d = 1'b0;
    if (take) begin
      last_page_d = page_of(CORE_REQ.addr, MEM_CFG.page_shift);
      page_d = last_page_d != last_page_q;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      last_page_q <= '0;
      page_q <= 1'b0;
    end else if (CLK_EN) begin
      last_page_q <= last_page_d;
      page_q <= page_d;
    end
  end

  // read data held until the next read, not cleared
  always_comb begin
    rvalid_d = 1'b0;
    rdata_d = rdata_q;
    if (done && !write_q) begin
      rvalid_d = 1'b1;
      rdata_d = DATA_MEM_DATA_I;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
    end else if (CLK_EN) begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
    end
  end

  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    write_d = write_q;
    bank_d = bank_q;
    rd_n_d = 1'b1;
    wr_n_d = 1'b1;
    ready_d = 1'b0;
    halt_d = 1'b0;
    grant_n_d = 1'b1;
    addr_oe_d = 1'b1;
    ctrl_oe_d = 1'b1;
    data_oe_d = 1'b0;
    unique case (state_q)
      DMBI_IDLE: begin
        bank_d = {BANKS{1'b1}};
        if (breq_sync_q) begin
          state_d = DMBI_GRANT;
          halt_d = 1'b1;
          grant_n_d = 1'b0;
          addr_oe_d = 1'b0;
          ctrl_oe_d = 1'b0;
        end else if (CORE_REQ.valid) begin
          state_d = DMBI_ACCESS;
          addr_d = CORE_REQ.addr;
          wdata_d = CORE_REQ.wdata;
          write_d = CORE_REQ.write;
          bank_d = bank_sel_n;
          rd_n_d = CORE_REQ.write;
          wr_n_d = ~CORE_REQ.write;
          data_oe_d = CORE_REQ.write;
        end else begin
          ready_d = 1'b1;
        end
      end
      DMBI_ACCESS: begin
        rd_n_d = write_q;
        wr_n_d = ~write_q;
        data_oe_d = write_q;
        if (floated) begin
          // access is left open; partner acks after release
          state_d = DMBI_FLOAT;
          halt_d = 1'b1;
          addr_oe_d = 1'b0;
          ctrl_oe_d = 1'b0;
          data_oe_d = 1'b0;
        end else if (DATA_MEM_ACKNOWLEDGE) begin
          // current cycle completes before any grant
          state_d = DMBI_IDLE;
          rd_n_d = 1'b1;
          wr_n_d = 1'b1;
          data_oe_d = 1'b0;
          bank_d = {BANKS{1'b1}};
          ready_d = ~breq_sync_q;
        end else begin
          halt_d = 1'b1;
        end
      end
      DMBI_FLOAT: begin
        halt_d = 1'b1;
        addr_oe_d = 1'b0;
        ctrl_oe_d = 1'b0;
        if (!floated) begin
          // redrive and resume; ack must follow release
          state_d = DMBI_ACCESS;
          addr_oe_d = 1'b1;
          ctrl_oe_d = 1'b1;
          rd_n_d = write_q;
          wr_n_d = ~write_q;
          data_oe_d = write_q;
        end
      end
      DMBI_GRANT: begin
        halt_d = 1'b1;
        grant_n_d = 1'b0;
        addr_oe_d = 1'b0;
        ctrl_oe_d = 1'b0;
        if (!breq_sync_q) begin
          state_d = DMBI_IDLE;
          grant_n_d = 1'b1;
          halt_d = 1'b0;
          addr_oe_d = 1'b1;
          ctrl_oe_d = 1'b1;
        end
      end
    endcase
  end

  // no clock gating: clk_en only holds state
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      state_q <= DMBI_IDLE;
      addr_q <= '0;
      wdata_q <= '0;
      write_q <= 1'b0;
      bank_q <= {BANKS{1'b1}};
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      ready_q <= 1'b0;
      halt_q <= 1'b0;
      grant_n_q <= 1'b1;
      addr_oe_q <= 1'b0;
      data_oe_q <= 1'b0;
      ctrl_oe_q <= 1'b0;
    end else if (CLK_EN) begin
      state_q <= state_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      write_q <= write_d;
      bank_q <= bank_d;
      rd_n_q <= rd_n_d;
      wr_n_q <= wr_n_d;
      ready_q <= ready_d;
      halt_q <= halt_d;
      grant_n_q <= grant_n_d;
      addr_oe_q <= addr_oe_d;
      data_oe_q <= data_oe_d;
      ctrl_oe_q <= ctrl_oe_d;
    end
  end

  assign CORE_READY = ready_q;
  assign CORE_HALT = halt_q;
  assign CORE_RDATA = rdata_q;
  assign CORE_RVALID = rvalid_q;
  assign DATA_MEM_ADDR_O = addr_q;
  assign DATA_MEM_ADDR_OE = addr_oe_q;
  assign DATA_MEM_DATA_O = wdata_q;
  assign DATA_MEM_DATA_OE = data_oe_q;
  assign DATA_MEM_BANK_SELECT_N_O = bank_q;
  assign DATA_MEM_READ_STROBE_N_O = rd_n_q;
  assign DATA_MEM_WRITE_STROBE_N_O = wr_n_q;
  assign DATA_MEM_CTRL_OE = ctrl_oe_q;
  assign DATA_MEM_PAGE_CROSS = page_q;
  assign BUS_GRANT_N = grant_n_q;
endmodule
`default_nettype wire

// ---- dmbi_core_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module dmbi_core_properties (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire dmbi_pkg::dmbi_req_type CORE_REQ,
  input wire logic CORE_READY,
  input wire logic CORE_RVALID,
  input wire logic DATA_MEM_ADDR_OE,
  input wire logic DATA_MEM_CTRL_OE,
  input wire logic DATA_MEM_READ_STROBE_N_O,
  input wire logic DATA_MEM_WRITE_STROBE_N_O,
  input wire logic DATA_MEM_ACKNOWLEDGE,
  input wire logic DATA_MEM_FLOAT_CONTROL_N,
  input wire logic BUS_REQUEST_N,
  input wire logic BUS_GRANT_N
);
  import dmbi_pkg::*;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  wire logic rd = DATA_MEM_CTRL_OE && !DATA_MEM_READ_STROBE_N_O;
  wire logic wr = DATA_MEM_CTRL_OE && !DATA_MEM_WRITE_STROBE_N_O;
  wire logic off = !DATA_MEM_ADDR_OE && !DATA_MEM_CTRL_OE;
  wire logic rq = !BUS_REQUEST_N;
  // only a request the synchroniser has not seen is taken
  sequence take;
    CORE_READY && CORE_REQ.valid && !rq && !$past(rq) && !$past(rq, 2);
  endsequence
  a_read_strobe: assert property (take ##0 !CORE_REQ.write |=> rd)
    else $error("read strobe missing");
  a_write_strobe: assert property (take ##0 CORE_REQ.write |=> wr)
    else $error("write strobe missing");
  a_wait_hold: assert property (
    (rd || wr) && !DATA_MEM_ACKNOWLEDGE && DATA_MEM_FLOAT_CONTROL_N
    |=> $stable({rd, wr})) else $error("access ended without ack");
  a_float_off: assert property (
    (rd || wr) && !DATA_MEM_FLOAT_CONTROL_N |=> off)
    else $error("bus not floated");
  a_float_undone: assert property (
    !DATA_MEM_FLOAT_CONTROL_N [*2] |=> !CORE_RVALID)
    else $error("floated access completed");
  a_grant_off: assert property (!BUS_GRANT_N |-> off)
    else $error("bus driven while granted");
  a_grant_hold: assert property (
    rq [*3] ##0 !BUS_GRANT_N |=> !BUS_GRANT_N)
    else $error("grant dropped early");
  a_grant_free: assert property (!rq [*5] |-> BUS_GRANT_N)
    else $error("grant not released");
endmodule
bind dmbi_core dmbi_core_properties u_dmbi_core_properties (.*);
`default_nettype wire

// ---- dmbi_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dmbi_mem_model (
  input wire logic clk,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [3:0] addr,
  input wire logic [39:0] wd,
  input wire logic [1:0] waits,
  output logic ack,
  output logic [39:0] rd
);
  logic [39:0] mem [16];
  logic [39:0] last = '0;
  int cnt = 0;
  initial foreach (mem[i]) mem[i] = '0;
  assign ack = cnt >= waits;
  // released bus shows the inverse of the last word, never a held value
  assign rd = rd_n ? ~last : mem[addr];
  always @(posedge clk) begin
    cnt <= (rd_n && wr_n) ? 0 : cnt + 1;
    if (!rd_n) last <= mem[addr];
    if (!wr_n && ack) mem[addr] <= wd;
  end
endmodule
`default_nettype wire

// ---- dmbi_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(e, s, n) begin tests_run++; if ((s) !== (e)) begin \
  n_errors++; $display("ERROR %s exp %h got %h", n, e, s); end end
module dmbi_bench;
  import dmbi_pkg::*;
  logic CLOCK = 0, NRST = 0, CLK_EN = 1, CORE_READY, CORE_HALT, CORE_RVALID;
  dmbi_req_type CORE_REQ = '0;
  dmbi_cfg_type MEM_CFG = '{5'h03, 5'h04};
  logic DATA_MEM_ADDR_OE, DATA_MEM_DATA_OE, DATA_MEM_CTRL_OE, BUS_GRANT_N;
  logic DATA_MEM_READ_STROBE_N_O, DATA_MEM_WRITE_STROBE_N_O;
  logic DATA_MEM_PAGE_CROSS, DATA_MEM_ACKNOWLEDGE;
  logic DATA_MEM_FLOAT_CONTROL_N = 1, BUS_REQUEST_N = 1;
  logic [39:0] CORE_RDATA, DATA_MEM_DATA_I, DATA_MEM_DATA_O, em [16];
  logic [31:0] DATA_MEM_ADDR_O;
  logic [28:0] pp = '0;
  logic [3:0] DATA_MEM_BANK_SELECT_N_O;
  logic [1:0] waits = 0;
  int n_errors = 0, tests_run = 0, cycles = 0;
  dmbi_core u_dmbi_core (.*);
  dmbi_mem_model u_dmbi_mem_model (.clk(CLOCK),
    .rd_n(!DATA_MEM_CTRL_OE || DATA_MEM_READ_STROBE_N_O),
    .wr_n(!DATA_MEM_CTRL_OE || DATA_MEM_WRITE_STROBE_N_O),
    .addr(DATA_MEM_ADDR_O[3:0]), .wd(DATA_MEM_DATA_O), .waits(waits),
    .ack(DATA_MEM_ACKNOWLEDGE), .rd(DATA_MEM_DATA_I));
  initial forever #4 CLOCK = ~CLOCK;
  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask
  task automatic acc(input logic w, logic [31:0] a, logic [39:0] d, bit f);
    int t = 0;
    logic sn;
    waits = f ? 2'h3 : 2'($urandom);
    CORE_REQ = '{1'b1, w, a, d};
    tick(1);
    CORE_REQ.valid = 0;
    sn = w ? DATA_MEM_WRITE_STROBE_N_O : DATA_MEM_READ_STROBE_N_O;
    `CHK(1'b0, sn, "strobe")
    `CHK(w, DATA_MEM_DATA_OE, "data_oe")
    `CHK(a, DATA_MEM_ADDR_O, "addr")
    `CHK(~(4'h1 << a[5:4]), DATA_MEM_BANK_SELECT_N_O, "bank")
    `CHK(a[31:3] != pp, DATA_MEM_PAGE_CROSS, "page")
    pp = a[31:3];
    if (w) `CHK(d, DATA_MEM_DATA_O, "wdata")
    if (f) begin
      DATA_MEM_FLOAT_CONTROL_N = 0;
      tick(2);
      `CHK(1'b0, DATA_MEM_ADDR_OE | DATA_MEM_CTRL_OE, "float")
      `CHK(1'b1, CORE_HALT, "halt")
      waits = 0;
      DATA_MEM_FLOAT_CONTROL_N = 1;
    end
    while (CORE_READY !== 1'b1 && t < 50) begin
      tick(1);
      t++;
    end
    `CHK(1'b1, CORE_READY, "done")
    `CHK(!w, CORE_RVALID, "rvalid")
    if (w) em[a[3:0]] = d;
    else `CHK(em[a[3:0]], CORE_RDATA, "rdata")
  endtask
  initial begin
    foreach (em[i]) em[i] = '0;
    void'($urandom(32'h5f19cb59));
    tick(16);
    NRST = 1;
    tick(2);
    for (int i = 0; i < 60; i++)
      acc(1'($urandom), $urandom & 32'hff, {$urandom, 8'($urandom)}, 0);
    acc(0, 32'h3c, 0, 1);
    BUS_REQUEST_N = 0;
    tick(6);
    `CHK(1'b0, BUS_GRANT_N | DATA_MEM_ADDR_OE, "grant")
    tick(8);
    `CHK(1'b0, BUS_GRANT_N, "hold")
    BUS_REQUEST_N = 1;
    tick(6);
    `CHK(1'b1, BUS_GRANT_N, "regain")
    CLK_EN = 0;
    BUS_REQUEST_N = 0;
    tick(5);
    `CHK(1'b1, BUS_GRANT_N, "frozen")
    BUS_REQUEST_N = 1;
    CLK_EN = 1;
    tick(2);
    acc(0, 32'h3c, 0, 0);
    final_report();
  end
endmodule
`default_nettype wire
